// ### hw/dcm_register_bank.v
// What this block does
// - A frame with phy address bit 0 low goes to channel A, high to channel B.
// - Control registers 0x01 to 0x0E exist once per channel and, with the broadcast bit clear, a write reaches only its own copy.
// - Status registers 0x0F to 0x15 and 0x1D return the status of the addressed channel.
// - Every other register is one shared copy, the same for both channels.
// - A read-write bit reads back the last value written to it.
// - A self-clearing bit turns a written 1 into one control pulse and always reads 0.
// - A read-only bit ignores writes and reads its live value.
// - A latched-high bit catches 1, holds it until read, and a read clears it.
// - A latched-low bit catches 0, holds it until read, and a read sets it.
// - A clear-on-read bit ignores writes, reads its value and then clears to 0.
// - Writing 1 to bit 15 of the chip-wide control resets both datapaths and all registers.
// - The chip-wide reset bit comes out of reset at 1 and falls back to 0 by itself one cycle later.
// - The chip-wide reset bit falls back to 0 by itself one cycle after a 1 is written.
// - With the broadcast bit set, control writes to 0x01 to 0x0E update both channels.
// - Writes to invalid or read-only registers are ignored and invalid reads return 0.
// - The block answers only when phy address bits 4:1 match the port address pins.
`include "dcm_consts.vh"
`default_nettype none

module dcm_register_bank (
  // Clock and reset
  input wire ref_clk,
  input wire reset_n,
  // Management link pins
  input wire mdc,
  input wire mdioIn,
  output reg mdioOut,
  output reg mdioOe,
  input wire [3:0] port_address_pins,
  // Per-channel status sources, channel B in the upper half
  input wire [31:0] chLive,
  input wire [31:0] chHiEvent,
  input wire [31:0] chLoCond,
  input wire [1:0] chErrEvent,
  // Control outputs
  output reg [15:0] globalCtrl,
  output wire [447:0] chanCtrl,
  output reg [1:0] self_clearing_pulse_bit,
  output reg datapathReset
);

  localparam [2:0] ST_HUNT = 3'd0;
  localparam [2:0] ST_HDR = 3'd1;
  localparam [2:0] ST_RTA = 3'd2;
  localparam [2:0] ST_RDAT = 3'd3;
  localparam [2:0] ST_WDAT = 3'd4;

  reg [1:0] rstPipe;
  reg [2:0] mdcSync;
  reg [1:0] mdioSync;
  reg [3:0] paMeta;
  reg [3:0] paSync;
  reg [2:0] state;
  reg [5:0] oneCnt;
  reg [4:0] bitCnt;
  reg [11:0] hdr;
  reg [4:0] regAddr;
  reg regCh;
  reg [15:0] shreg;
  reg rdStrobe;
  reg wrStrobe;
  reg [15:0] rdData;
  reg [15:0] ctrlMem [0:27];
  integer i;

  wire [15:0] statA;
  wire [15:0] statB;

  // Reset is released through two flops; everything else uses this copy
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rstPipe <= 2'b00;
    end else begin
      rstPipe <= {rstPipe[0], 1'b1};
    end
  end
  wire rstN = rstPipe[1];

  // Pin synchronisers; MDC gets a third stage for edge detection
  always @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      mdcSync <= 3'h0;
      mdioSync <= 2'h3;
      paMeta <= 4'h0;
      paSync <= 4'h0;
    end else begin
      mdcSync <= {mdcSync[1:0], mdc};
      mdioSync <= {mdioSync[0], mdioIn};
      paMeta <= port_address_pins;
      paSync <= paMeta;
    end
  end

  wire mdcRise = mdcSync[1] & ~mdcSync[2];
  wire mdioBit = mdioSync[1];

  // Header fields: start bit, opcode, phy_address_field, register address
  wire [12:0] hdrFull = {hdr, mdioBit};
  wire [1:0] hdrOp = hdrFull[11:10];
  wire [3:0] hdrPaHigh = hdrFull[9:6];
  wire hdrChan = hdrFull[5];
  wire [4:0] hdrReg = hdrFull[4:0];
  wire hdrMatch = (hdrFull[12] == `DCM_START_BIT) && (hdrPaHigh == paSync);

  // Frame sequencer; one step per rising MDC edge, data driven just after the edge
  always @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      state <= ST_HUNT;
      oneCnt <= 6'd0;
      bitCnt <= 5'd0;
      hdr <= 12'h000;
      regAddr <= 5'h00;
      regCh <= 1'b0;
      shreg <= 16'h0000;
      rdStrobe <= 1'b0;
      wrStrobe <= 1'b0;
      mdioOut <= 1'b0;
      mdioOe <= 1'b0;
    end else begin
      rdStrobe <= 1'b0;
      wrStrobe <= 1'b0;
      // Read data is sampled in the same cycle the status clears act
      if (rdStrobe) begin
        shreg <= rdData;
      end
      if (mdcRise) begin
        case (state)
          ST_HUNT: begin
            if (mdioBit) begin
              if (oneCnt != `DCM_PREAMBLE_LEN) begin
                oneCnt <= oneCnt + 6'd1;
              end
            end else begin
              // First start bit after a full preamble opens a frame
              if (oneCnt == `DCM_PREAMBLE_LEN) begin
                state <= ST_HDR;
                bitCnt <= 5'd0;
              end
              oneCnt <= 6'd0;
            end
          end
          ST_HDR: begin
            hdr <= hdrFull[11:0];
            bitCnt <= bitCnt + 5'd1;
            if (bitCnt == `DCM_HDR_LAST) begin
              regAddr <= hdrReg;
              regCh <= hdrChan;
              bitCnt <= 5'd0;
              if (hdrMatch && hdrOp == `DCM_OP_READ) begin
                rdStrobe <= 1'b1;
                state <= ST_RTA;
              end else if (hdrMatch && hdrOp == `DCM_OP_WRITE) begin
                state <= ST_WDAT;
              end else begin
                // Not ours: stay silent and wait for the next preamble
                state <= ST_HUNT;
              end
            end
          end
          ST_RTA: begin
            // First turnaround bit stays released; drive the 0 for the second
            mdioOe <= 1'b1;
            mdioOut <= 1'b0;
            bitCnt <= 5'd0;
            state <= ST_RDAT;
          end
          ST_RDAT: begin
            if (bitCnt == `DCM_RD_BITS) begin
              mdioOe <= 1'b0;
              mdioOut <= 1'b0;
              state <= ST_HUNT;
            end else begin
              mdioOut <= shreg[15];
              shreg <= {shreg[14:0], 1'b0};
              bitCnt <= bitCnt + 5'd1;
            end
          end
          ST_WDAT: begin
            // Two turnaround bits fall off the top of the shifter
            shreg <= {shreg[14:0], mdioBit};
            bitCnt <= bitCnt + 5'd1;
            if (bitCnt == `DCM_WR_LAST) begin
              wrStrobe <= 1'b1;
              state <= ST_HUNT;
            end
          end
          default: begin
            state <= ST_HUNT;
          end
        endcase
      end
    end
  end

  // Address decode for the latched access
  wire bcast = globalCtrl[`DCM_BCAST_BIT];
  wire inCtrl = (regAddr >= `DCM_CTRL_FIRST) && (regAddr <= `DCM_CTRL_LAST);
  wire inStat = ((regAddr >= `DCM_STAT_FIRST) && (regAddr <= `DCM_STAT_LAST)) ||
    (regAddr == `DCM_STAT_EXTRA);
  wire [4:0] ctrlIdx = (regCh ? `DCM_CTRL_COUNT : 5'd0) + regAddr - 5'd1;
  wire [4:0] peerIdx = (regCh ? 5'd0 : `DCM_CTRL_COUNT) + regAddr - 5'd1;
  wire scHit = wrStrobe && (regAddr == `DCM_SC_ADDR) && shreg[`DCM_SC_BIT];
  // The pulse bit is never stored, so it reads 0
  wire [15:0] wrWord = (regAddr == `DCM_SC_ADDR) ? (shreg & ~`DCM_SC_MASK) : shreg;

  // Register storage; the chip-wide reset bit acts as one extra reset cycle
  always @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      globalCtrl <= `DCM_GCTL_RESET;
      for (i = 0; i < 28; i = i + 1) begin
        ctrlMem[i] <= (i % 14 == 0) ? `DCM_CTRL1_RESET : `DCM_CTRL_RESET;
      end
      self_clearing_pulse_bit <= 2'b00;
      datapathReset <= 1'b1;
    end else if (datapathReset) begin
      // Same effect as the reset pin, except that this bit itself drops to 0
      globalCtrl <= `DCM_GCTL_RESET;
      for (i = 0; i < 28; i = i + 1) begin
        ctrlMem[i] <= (i % 14 == 0) ? `DCM_CTRL1_RESET : `DCM_CTRL_RESET;
      end
      self_clearing_pulse_bit <= 2'b00;
      datapathReset <= 1'b0;
    end else begin
      datapathReset <= wrStrobe && (regAddr == `DCM_GCTL_ADDR) && shreg[`DCM_GRST_BIT];
      self_clearing_pulse_bit <= {scHit && (regCh || bcast), scHit && (!regCh || bcast)};
      if (wrStrobe) begin
        // Status and unmapped addresses fall through untouched
        if (regAddr == `DCM_GCTL_ADDR) begin
          globalCtrl <= shreg & `DCM_GCTL_RW_MASK;
        end
        if (inCtrl) begin
          ctrlMem[ctrlIdx] <= wrWord;
          if (bcast) begin
            ctrlMem[peerIdx] <= wrWord;
          end
        end
      end
    end
  end

  // Control words out, channel A in entries 0..13, channel B in 14..27
  genvar g;
  generate
    for (g = 0; g < 28; g = g + 1) begin : gCtrlOut
      assign chanCtrl[g*16 +: 16] = ctrlMem[g];
    end
  endgenerate

  // Read mux; anything not decoded returns zero
  always @* begin
    rdData = 16'h0000;
    if (regAddr == `DCM_GCTL_ADDR) begin
      rdData = globalCtrl;
    end else if (inCtrl) begin
      rdData = ctrlMem[ctrlIdx];
    end else if (inStat) begin
      rdData = regCh ? statB : statA;
    end
  end

  // Per-channel status; only the addressed channel sees the read side effects
  dcm_chan_status uStatA (
    .clk(ref_clk),
    .rstN(rstN),
    .clr(datapathReset),
    .live(chLive[15:0]),
    .hiEvent(chHiEvent[15:0]),
    .loCond(chLoCond[15:0]),
    .errEvent(chErrEvent[0]),
    .rdStrobe(rdStrobe && inStat && !regCh),
    .rdAddr(regAddr),
    .rdData(statA)
  );

  dcm_chan_status uStatB (
    .clk(ref_clk),
    .rstN(rstN),
    .clr(datapathReset),
    .live(chLive[31:16]),
    .hiEvent(chHiEvent[31:16]),
    .loCond(chLoCond[31:16]),
    .errEvent(chErrEvent[1]),
    .rdStrobe(rdStrobe && inStat && regCh),
    .rdAddr(regAddr),
    .rdData(statB)
  );

endmodule // dcm_register_bank

`default_nettype wire

// ### hw/dcm_consts.vh
`ifndef DCM_CONSTS_VH
`define DCM_CONSTS_VH

// Register addresses
`define DCM_GCTL_ADDR 5'h00
`define DCM_CTRL_FIRST 5'h01
`define DCM_CTRL_LAST 5'h0e
`define DCM_CTRL_COUNT 5'h0e
`define DCM_STAT_FIRST 5'h0f
`define DCM_STAT_LAST 5'h15
`define DCM_STAT_EXTRA 5'h1d

// Chip-wide control layout and reset
`define DCM_GCTL_RESET 16'h0600
`define DCM_GCTL_RW_MASK 16'h0f8f
`define DCM_GRST_BIT 15
`define DCM_BCAST_BIT 11

// Per-channel control reset values
`define DCM_CTRL1_RESET 16'h0300
`define DCM_CTRL_RESET 16'h0000

// Self-clearing pulse bit in per-channel control
`define DCM_SC_ADDR 5'h0e
`define DCM_SC_BIT 0
`define DCM_SC_MASK 16'h0001

// Per-channel status registers
`define DCM_ST_LIVE 5'h0f
`define DCM_ST_LH 5'h10
`define DCM_ST_LL 5'h11
`define DCM_ST_COR 5'h1d
`define DCM_LL_RESET 16'hffff

// Management frame
`define DCM_PREAMBLE_LEN 6'd32
`define DCM_HDR_LAST 5'd12
`define DCM_RD_BITS 5'd16
`define DCM_WR_LAST 5'd17
`define DCM_START_BIT 1'b1
`define DCM_OP_READ 2'b10
`define DCM_OP_WRITE 2'b01

`endif

// ### hw/dcm_chan_status.v
`include "dcm_consts.vh"
`default_nettype none

// Status set of one channel: live, latched-high, latched-low, clear-on-read
module dcm_chan_status (
  // Clock and reset
  input wire clk,
  input wire rstN,
  input wire clr,
  // Status sources from outside this clock domain
  input wire [15:0] live,
  input wire [15:0] hiEvent,
  input wire [15:0] loCond,
  input wire errEvent,
  // Read port
  input wire rdStrobe,
  input wire [4:0] rdAddr,
  output reg [15:0] rdData
);

  reg [15:0] liveM;
  reg [15:0] liveS;
  reg [15:0] hiM;
  reg [15:0] hiS;
  reg [15:0] loM;
  reg [15:0] loS;
  reg [2:0] errS;
  reg [15:0] latchedHigh;
  reg [15:0] latchedLow;
  reg [15:0] errCount;

  wire rdLH = rdStrobe && (rdAddr == `DCM_ST_LH);
  wire rdLL = rdStrobe && (rdAddr == `DCM_ST_LL);
  wire rdCor = rdStrobe && (rdAddr == `DCM_ST_COR);
  wire errRise = errS[1] & ~errS[2];

  // Two-flop synchronisers; only the second stage feeds logic, except errS, whose third stage feeds the edge detect
  always @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      liveM <= 16'h0000;
      liveS <= 16'h0000;
      hiM <= 16'h0000;
      hiS <= 16'h0000;
      loM <= 16'h0000;
      loS <= 16'h0000;
      errS <= 3'h0;
    end else begin
      liveM <= live;
      liveS <= liveM;
      hiM <= hiEvent;
      hiS <= hiM;
      loM <= loCond;
      loS <= loM;
      errS <= {errS[1:0], errEvent};
    end
  end

  // Sticky bits; a new event in the read cycle wins over the clear
  always @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      latchedHigh <= 16'h0000;
      latchedLow <= `DCM_LL_RESET;
      errCount <= 16'h0000;
    end else if (clr) begin
      latchedHigh <= 16'h0000;
      latchedLow <= `DCM_LL_RESET;
      errCount <= 16'h0000;
    end else begin
      latchedHigh <= (latchedHigh & ~{16{rdLH}}) | hiS;
      latchedLow <= (latchedLow | {16{rdLL}}) & ~loS;
      if (errRise) begin
        // Saturates so a flood of errors never wraps to a small count
        if (rdCor) begin
          errCount <= 16'h0001;
        end else if (errCount != 16'hffff) begin
          errCount <= errCount + 16'h0001;
        end
      end else if (rdCor) begin
        errCount <= 16'h0000;
      end
    end
  end

  // Read mux; unimplemented status addresses read zero
  always @* begin
    case (rdAddr)
      `DCM_ST_LIVE: rdData = liveS;
      `DCM_ST_LH: rdData = latchedHigh;
      `DCM_ST_LL: rdData = latchedLow;
      `DCM_ST_COR: rdData = errCount;
      default: rdData = 16'h0000;
    endcase
  end

endmodule // dcm_chan_status

`default_nettype wire

// ### bench/dcm_register_bank_chk.sv
`default_nettype none
module dcm_register_bank_chk (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // Watched outputs
  input wire logic mdioOut,
  input wire logic mdioOe,
  input wire logic [15:0] globalCtrl,
  input wire logic [447:0] chanCtrl,
  input wire logic [1:0] self_clearing_pulse_bit,
  input wire logic datapathReset
);
  logic [7:0] oeCnt;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!reset_n);
  // Length of one driven reply; 17 link periods plus sync slack
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) oeCnt <= 8'h00;
    else oeCnt <= mdioOe ? oeCnt + 8'h01 : 8'h00;
  end
  a_gctl_fixed_zero: assert property (
    (globalCtrl & 16'hf070) == 16'h0000)
    else $error("chip-wide control holds a reset or unused bit");
  a_pulse_one_cycle: assert property (
    |self_clearing_pulse_bit |=> self_clearing_pulse_bit == 2'b00)
    else $error("control pulse longer than one cycle");
  a_soft_reset_vals: assert property (
    $rose(datapathReset) |=> globalCtrl == 16'h0600 && chanCtrl[31:0] == 32'h00000300)
    else $error("registers not back at reset values after soft reset");
  a_turnaround_zero: assert property (
    $rose(mdioOe) |-> !mdioOut [*6])
    else $error("second turnaround bit not driven low");
  a_reply_length: assert property (oeCnt <= 8'd140)
    else $error("reply drives the line too long");
  a_ctrl_no_read: assert property ($changed(chanCtrl) |-> !mdioOe)
    else $error("control changed during a read reply");
  a_bcast_entry: assert property (
    $changed(chanCtrl[31:16]) && globalCtrl[11] |-> chanCtrl[31:16] == chanCtrl[255:240])
    else $error("broadcast write reached one channel only");
  a_bcast_pulse: assert property (
    self_clearing_pulse_bit[0] && globalCtrl[11] |-> self_clearing_pulse_bit[1])
    else $error("broadcast pulse missing on channel B");
endmodule // dcm_register_bank_chk

bind dcm_register_bank dcm_register_bank_chk u_chk (.ref_clk, .reset_n, .mdioOut, .mdioOe,
  .globalCtrl, .chanCtrl, .self_clearing_pulse_bit, .datapathReset);
`default_nettype wire

// ### bench/dcm_mdio_station.sv
`default_nettype none
module dcm_mdio_station (
  // Link pins
  output logic mdc,
  output wire logic mdioIn,
  input wire logic mdioOut,
  input wire logic mdioOe
);
  timeunit 1ns;
  timeprecision 100ps;
  logic drv = 1'b0;
  logic bitv = 1'b1;
  logic smp;
  // Pull-up wins when nobody drives the line
  assign mdioIn = mdioOe ? mdioOut : (drv ? bitv : 1'b1);
  initial mdc = 1'b0;
  // One link bit: data set while low, taken just before the rise
  task automatic tick(input logic b, input logic d);
    mdc = 1'b0;
    drv = d;
    bitv = b;
    #100;
    smp = mdioIn;
    mdc = 1'b1;
    #100;
  endtask
  // Whole frame; clock stands low between frames
  task automatic xfer(input logic [1:0] op, input logic [4:0] pa, input logic [4:0] ra,
                      input logic [15:0] wd, output logic [15:0] rd);
    logic [45:0] hdr;
    logic [17:0] body;
    hdr = {32'hffffffff, 2'b01, op, pa, ra};
    body = {2'b10, wd};
    rd = 16'h0000;
    for (int i = 45; i >= 0; i--) tick(hdr[i], 1'b1);
    for (int i = 17; i >= 0; i--) begin
      tick(body[i], op == 2'b01);
      if (i < 16) rd = {rd[14:0], smp};
    end
    mdc = 1'b0;
    drv = 1'b0;
    #300;
  endtask
endmodule // dcm_mdio_station
`default_nettype wire

// ### bench/dcm_register_bank_tb.sv
`include "dcm_consts.vh"
`default_nettype none
module dcm_register_bank_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [3:0] portPins = 4'ha;
  logic [31:0] live = 32'h0;
  logic [31:0] hiEv = 32'h0;
  logic [31:0] loCond = 32'h0;
  logic [1:0] errEv = 2'b00;
  logic [31:0] lfsr = 32'h26be8d31;
  logic [15:0] v;
  int err_total = 0;
  int n_checks = 0;
  int cyc = 0;
  int scA = 0;
  int scB = 0;
  wire mdc;
  wire mdioIn;
  wire mdioOut;
  wire mdioOe;
  wire [15:0] gctl;
  wire [447:0] cctl;
  wire [1:0] scp;
  wire dpr;
  initial begin
    forever #12.5 ref_clk = ~ref_clk;
  end
  dcm_register_bank u_dut (.ref_clk(ref_clk), .reset_n(reset_n), .mdc(mdc),
    .mdioIn(mdioIn), .mdioOut(mdioOut), .mdioOe(mdioOe), .port_address_pins(portPins),
    .chLive(live), .chHiEvent(hiEv), .chLoCond(loCond), .chErrEvent(errEv),
    .globalCtrl(gctl), .chanCtrl(cctl), .self_clearing_pulse_bit(scp), .datapathReset(dpr));
  dcm_mdio_station u_sta (.mdc(mdc), .mdioIn(mdioIn), .mdioOut(mdioOut), .mdioOe(mdioOe));
  // Pulse counters and hang guard
  always @(posedge ref_clk) begin
    // Pulses are unknown until the async reset has reached them, so count only after release
    if (reset_n) begin
      scA += scp[0];
      scB += scp[1];
    end
    cyc++;
    if (cyc == 90000) begin
      err_total++;
      tally_and_finish();
    end
  end
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [15:0] expG(input logic [15:0] w);
    return w & `DCM_GCTL_RW_MASK;
  endfunction
  function automatic logic [4:0] pa(input logic ch);
    return {portPins, ch};
  endfunction
  task automatic chk(input logic [15:0] seen, input logic [15:0] want);
    n_checks++;
    if (seen !== want) begin
      err_total++;
      $display("mismatch at %0t seen %h want %h", $time, seen, want);
    end
  endtask
  // Inputs move a fixed 2 ns after the rising edge
  task automatic clk(input int n);
    repeat (n) @(posedge ref_clk);
    #2;
  endtask
  task automatic wr(input logic [4:0] p, input logic [4:0] r, input logic [15:0] d);
    logic [15:0] x;
    u_sta.xfer(`DCM_OP_WRITE, p, r, d, x);
  endtask
  task automatic rd(input logic [4:0] p, input logic [4:0] r, output logic [15:0] d);
    u_sta.xfer(`DCM_OP_READ, p, r, 16'h0000, d);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    clk(5);
    reset_n = 1'b1;
    clk(8);
    rd(pa(1), 5'h00, v);
    chk(v, `DCM_GCTL_RESET);
    rd(pa(0), 5'h01, v);
    chk(v, `DCM_CTRL1_RESET);
    $display("test reset values done");
    // Random per-channel words at control addresses 0x01 to 0x0D
    for (int k = 1; k < 14; k++) begin
      lfsr = nxt(lfsr);
      wr(pa(0), 5'(k), lfsr[15:0]);
      wr(pa(1), 5'(k), lfsr[31:16]);
      rd(pa(0), 5'(k), v);
      chk(v, lfsr[15:0]);
      rd(pa(1), 5'(k), v);
      chk(v, lfsr[31:16]);
      chk(cctl[16*k-16 +: 16], lfsr[15:0]);
    end
    wr({~portPins, 1'b0}, 5'h0d, ~lfsr[15:0]);
    rd({~portPins, 1'b0}, 5'h0d, v);
    chk(v, 16'hffff);
    rd(pa(0), 5'h0d, v);
    chk(v, lfsr[15:0]);
    $display("test channel split done");
    wr(pa(0), 5'h00, 16'h7fff);
    chk(gctl, expG(16'h7fff));
    rd(pa(1), 5'h00, v);
    chk(v, expG(16'h7fff));
    lfsr = nxt(lfsr);
    wr(pa(1), 5'h02, lfsr[15:0]);
    chk(cctl[31:16], lfsr[15:0]);
    chk(cctl[255:240], lfsr[15:0]);
    wr(pa(0), `DCM_SC_ADDR, 16'h0001);
    wr(pa(0), 5'h00, 16'h0600);
    wr(pa(1), `DCM_SC_ADDR, 16'h0001);
    chk(16'(scA), 16'h0001);
    chk(16'(scB), 16'h0002);
    rd(pa(1), `DCM_SC_ADDR, v);
    chk(v, 16'h0000);
    $display("test broadcast done");
    lfsr = nxt(lfsr);
    live = lfsr;
    hiEv = 32'h00000004;
    loCond = 32'h00200000;
    repeat (3) begin
      errEv = 2'b01;
      clk(4);
      errEv = 2'b00;
      hiEv = 32'h0;
      loCond = 32'h0;
      clk(4);
    end
    wr(pa(0), `DCM_ST_LIVE, ~live[15:0]);
    rd(pa(0), `DCM_ST_LIVE, v);
    chk(v, live[15:0]);
    rd(pa(1), `DCM_ST_LIVE, v);
    chk(v, live[31:16]);
    for (int n = 0; n < 2; n++) begin
      rd(pa(0), `DCM_ST_LH, v);
      chk(v, n ? 16'h0000 : 16'h0004);
      rd(pa(1), `DCM_ST_LL, v);
      chk(v, n ? `DCM_LL_RESET : `DCM_LL_RESET & ~16'h0020);
      wr(pa(0), `DCM_ST_COR, 16'h00ff);
      rd(pa(0), `DCM_ST_COR, v);
      chk(v, n ? 16'h0000 : 16'h0003);
    end
    rd(pa(1), `DCM_ST_LH, v);
    chk(v, 16'h0000);
    rd(pa(0), 5'h1e, v);
    chk(v, 16'h0000);
    $display("test status done");
    wr(pa(1), 5'h00, 16'h8000);
    rd(pa(0), 5'h00, v);
    chk(v, `DCM_GCTL_RESET);
    rd(pa(0), 5'h01, v);
    chk(v, `DCM_CTRL1_RESET);
    rd(pa(1), 5'h0d, v);
    chk(v, `DCM_CTRL_RESET);
    $display("test soft reset done");
    tally_and_finish();
  end
endmodule // dcm_register_bank_tb
`default_nettype wire
